// File: rtl/sdmi_pkg.sv
// Overview of operation
// - Only rising step edges count, unless double-edge mode makes both edges count.
// - Direction is sampled at each active step edge and decides that step.
// - Direction low adds to the microstep counter, high subtracts, scaled by resolution.
// - Resolutions are full step or 2 to 256 microsteps per full step.
// - The counter maps through an internal table to sine and cosine coil targets.
// - In step and direction operation the internal ramp generator stays idle.
// - An interpolator advances coil currents at 256-microstep granularity for coarse steps.
// - At standstill current drops to a hold level after a delay with decay.
// - Standstill may instead freewheel or passively brake the motor.
// - An optional faster standstill detection shortens the stop time.
package sdmi_pkg;
    localparam int unsigned CLK_MHZ = 20;
    // standstill detection and power-down tick times
    localparam int unsigned STILL_TIME_US = 50000;
    localparam int unsigned FAST_STILL_TIME_US = 2000;
    localparam int unsigned PD_TICK_US = 1000;
    localparam int unsigned STILL_CYC = STILL_TIME_US * CLK_MHZ;
    localparam int unsigned FAST_STILL_CYC = FAST_STILL_TIME_US * CLK_MHZ;
    localparam int unsigned PD_TICK_CYC = PD_TICK_US * CLK_MHZ;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CURCFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_COIL = 8'h0C;

    // control fields
    localparam int unsigned CTRL_MRES_LSB = 0;
    localparam int unsigned CTRL_DEDGE = 4;
    localparam int unsigned CTRL_INTERP = 5;
    localparam int unsigned CTRL_FAST = 6;
    localparam int unsigned CTRL_STILL_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
    localparam logic [31:0] CTRL_MASK = 32'h0000_037F;

    // current configuration fields
    localparam int unsigned CFG_IHOLD_LSB = 0;
    localparam int unsigned CFG_IRUN_LSB = 8;
    localparam int unsigned CFG_DELAY_LSB = 16;
    localparam int unsigned CFG_DECAY_LSB = 24;
    localparam logic [31:0] CURCFG_RESET = 32'h010A_1F08;
    localparam logic [31:0] CURCFG_MASK = 32'h0FFF_1F1F;

    // status and coil readback fields
    localparam int unsigned STAT_POS_LSB = 16;
    localparam int unsigned STAT_STILL = 28;
    localparam int unsigned STAT_EXT = 29;
    localparam int unsigned STAT_DIR = 30;
    localparam int unsigned COIL_B_LSB = 16;
    localparam int unsigned COIL_SCALE_LSB = 26;

    localparam logic [3:0] MRES_FULL = 4'h8;

    typedef enum logic [1:0] {
        SDMI_HOLD = 2'b00,
        SDMI_FREEWHEEL = 2'b01,
        SDMI_BRAKE = 2'b10,
        SDMI_RSVD = 2'b11
    } sdmi_still_t;

    // quarter sine anchor points, 16 segments, peak 248
    localparam logic [7:0] SINE_PTS [0:16] = '{
        8'h00, 8'h18, 8'h30, 8'h48, 8'h5F, 8'h75, 8'h8A, 8'h9D, 8'hAF,
        8'hBF, 8'hCE, 8'hDB, 8'hE5, 8'hEE, 8'hF4, 8'hF7, 8'hF8
    };
    localparam logic [8:0] QUARTER = 9'h100;
    localparam logic [9:0] COS_SHIFT = 10'h100;
endpackage : sdmi_pkg

// File: rtl/sdmi_sine.sv
`timescale 1ns/10ps
module sdmi_sine (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // position in
    input wire logic [9:0] pos_i,
    // coil targets, two's complement
    output logic [8:0] sin_o,
    output logic [8:0] cos_o
);
    logic [8:0] next_sin;
    logic [8:0] next_cos;

    function automatic logic [8:0] sdmi_wave(input logic [9:0] p);
        logic [8:0] x;
        logic [4:0] idx;
        logic [4:0] idx_hi;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [11:0] prod;
        logic [7:0] mag;
        x = p[8] ? 9'(sdmi_pkg::QUARTER - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
        idx = x[8:4];
        idx_hi = (idx == 5'h10) ? idx : 5'(idx + 5'h01);
        lo = sdmi_pkg::SINE_PTS[idx];
        hi = sdmi_pkg::SINE_PTS[idx_hi];
        prod = 12'(8'(hi - lo)) * 12'(x[3:0]);
        mag = 8'(lo + prod[11:4]);
        return p[9] ? 9'(-{1'b0, mag}) : {1'b0, mag};
    endfunction : sdmi_wave

    always_comb begin
        next_sin = sdmi_wave(pos_i);
        next_cos = sdmi_wave(10'(pos_i + sdmi_pkg::COS_SHIFT));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sin_o <= 9'h000;
            cos_o <= 9'h0F8;
        end else begin
            sin_o <= next_sin;
            cos_o <= next_cos;
        end
    end
endmodule : sdmi_sine

// File: rtl/sdmi_interp.sv
`timescale 1ns/10ps
module sdmi_interp (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // step events and setup
    input wire logic step_evt_i,
    input wire logic [9:0] target_i,
    input wire logic [3:0] mres_i,
    input wire logic interp_en_i,
    // smoothed position
    output logic [9:0] pos_o
);
    logic [19:0] period_cnt;
    logic [19:0] period_last;
    logic [19:0] rate_cnt;
    logic [9:0] next_pos;
    logic [19:0] next_period_cnt;
    logic [19:0] next_period_last;
    logic [19:0] next_rate_cnt;
    logic [9:0] diff;
    logic [19:0] rate;

    always_comb begin
        next_pos = pos_o;
        next_period_cnt = (period_cnt == 20'hFFFFF) ? period_cnt : 20'(period_cnt + 20'h1);
        next_period_last = period_last;
        next_rate_cnt = 20'(rate_cnt + 20'h1);
        diff = 10'(target_i - pos_o);
        rate = period_last >> mres_i;
        if (step_evt_i) begin
            // snap to the previous target so lag never exceeds one step
            next_pos = target_i;
            next_period_last = period_cnt;
            next_period_cnt = 20'h0;
            next_rate_cnt = 20'h0;
        end else if (!interp_en_i || period_last == 20'hFFFFF) begin
            next_pos = target_i;
        end else if (diff != 10'h000 && rate_cnt >= rate) begin
            next_pos = diff[9] ? 10'(pos_o - 10'h001) : 10'(pos_o + 10'h001);
            next_rate_cnt = 20'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_o <= 10'h000;
            period_cnt <= 20'hFFFFF;
            period_last <= 20'hFFFFF;
            rate_cnt <= 20'h0;
        end else begin
            pos_o <= next_pos;
            period_cnt <= next_period_cnt;
            period_last <= next_period_last;
            rate_cnt <= next_rate_cnt;
        end
    end
endmodule : sdmi_interp

// File: rtl/sdmi_indexer.sv
`timescale 1ns/10ps
module sdmi_indexer #(
    parameter int unsigned STILL_CYC = sdmi_pkg::STILL_CYC,
    parameter int unsigned FAST_STILL_CYC = sdmi_pkg::FAST_STILL_CYC,
    parameter int unsigned PD_TICK_CYC = sdmi_pkg::PD_TICK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // step and direction pins
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic external_pulse_mode_pin_i,
    // motor side
    output logic [8:0] coil_a_o,
    output logic [8:0] coil_b_o,
    output logic [4:0] cur_scale_o,
    output logic freewheel_o,
    output logic brake_o,
    output logic standstill_o,
    output logic ramp_gen_en_o
);
    // pin synchronisers
    logic [1:0] step_sync;
    logic [1:0] dir_sync;
    logic [1:0] ext_sync;
    logic step_prev;

    // registers
    logic [31:0] ctrl;
    logic [31:0] curcfg;
    logic [9:0] mscnt;
    logic dir_last;
    logic [19:0] still_cnt;
    logic still;
    logic [14:0] tick_cnt;
    logic [7:0] pd_cnt;
    logic [3:0] decay_cnt;
    logic [4:0] scale;
    logic [4:0] scale_out;
    logic free_out;
    logic brake_out;
    logic [9:0] pos;

    logic [31:0] next_ctrl;
    logic [31:0] next_curcfg;
    logic [9:0] next_mscnt;
    logic next_dir_last;
    logic [19:0] next_still_cnt;
    logic next_still;
    logic [14:0] next_tick_cnt;
    logic [7:0] next_pd_cnt;
    logic [3:0] next_decay_cnt;
    logic [4:0] next_scale;
    logic [4:0] next_scale_out;
    logic next_free_out;
    logic next_brake_out;
    logic next_ack;
    logic [31:0] next_dat;

    // decoded fields
    logic [3:0] mres;
    logic dedge;
    logic interp_en;
    logic fast_still;
    sdmi_pkg::sdmi_still_t still_mode;
    logic [4:0] ihold;
    logic [4:0] irun;
    logic [7:0] pd_delay;
    logic [3:0] decay;
    logic ext_mode;
    logic step_rise;
    logic step_fall;
    logic step_evt;
    logic [9:0] step_inc;
    logic tick;
    logic [19:0] still_lim;
    logic reduced;
    logic bus_req;
    logic [31:0] wmask;

    always_comb begin
        ext_mode = ext_sync[1];
        // resolution codes above full step act as full step
        mres = (ctrl[sdmi_pkg::CTRL_MRES_LSB +: 4] > sdmi_pkg::MRES_FULL) ?
            sdmi_pkg::MRES_FULL : ctrl[sdmi_pkg::CTRL_MRES_LSB +: 4];
        dedge = ctrl[sdmi_pkg::CTRL_DEDGE];
        interp_en = ctrl[sdmi_pkg::CTRL_INTERP];
        fast_still = ctrl[sdmi_pkg::CTRL_FAST];
        still_mode = sdmi_pkg::sdmi_still_t'(ctrl[sdmi_pkg::CTRL_STILL_LSB +: 2]);
        ihold = curcfg[sdmi_pkg::CFG_IHOLD_LSB +: 5];
        irun = curcfg[sdmi_pkg::CFG_IRUN_LSB +: 5];
        pd_delay = curcfg[sdmi_pkg::CFG_DELAY_LSB +: 8];
        decay = curcfg[sdmi_pkg::CFG_DECAY_LSB +: 4];
        step_rise = step_sync[1] & ~step_prev;
        step_fall = ~step_sync[1] & step_prev;
        step_evt = ext_mode & (step_rise | (dedge & step_fall));
        step_inc = 10'(10'h001 << mres);
        tick = (tick_cnt == 15'(PD_TICK_CYC - 1));
        still_lim = fast_still ? 20'(FAST_STILL_CYC) : 20'(STILL_CYC);
        // a step leaves freewheel or brake in the same cycle as standstill
        reduced = still && !step_evt && (pd_cnt == pd_delay) && (scale <= ihold);
        bus_req = cyc_i & stb_i & ~ack_o;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    end

    // step counting and standstill power-down
    always_comb begin
        next_mscnt = mscnt;
        next_dir_last = dir_last;
        next_still_cnt = still_cnt;
        next_still = still;
        next_tick_cnt = tick ? 15'h0000 : 15'(tick_cnt + 15'h0001);
        next_pd_cnt = pd_cnt;
        next_decay_cnt = decay_cnt;
        next_scale = scale;
        if (step_evt) begin
            next_dir_last = dir_sync[1];
            // wraps modulo one electrical period
            if (dir_sync[1]) begin
                next_mscnt = 10'(mscnt - step_inc);
            end else begin
                next_mscnt = 10'(mscnt + step_inc);
            end
            next_still_cnt = 20'h00000;
            next_still = 1'b0;
            next_pd_cnt = 8'h00;
            next_decay_cnt = 4'h0;
            next_scale = irun;
        end else if (!still) begin
            next_scale = irun;
            if (still_cnt >= 20'(still_lim - 1)) begin
                next_still = 1'b1;
            end else begin
                next_still_cnt = 20'(still_cnt + 20'h00001);
            end
        end else if (tick) begin
            if (pd_cnt != pd_delay) begin
                next_pd_cnt = 8'(pd_cnt + 8'h01);
            end else if (scale > ihold) begin
                if (decay_cnt >= decay) begin
                    next_decay_cnt = 4'h0;
                    next_scale = 5'(scale - 5'h01);
                end else begin
                    next_decay_cnt = 4'(decay_cnt + 4'h1);
                end
            end
        end
        if (scale < ihold && still) begin
            next_scale = ihold;
        end
        next_free_out = reduced && (still_mode == sdmi_pkg::SDMI_FREEWHEEL);
        next_brake_out = reduced && (still_mode == sdmi_pkg::SDMI_BRAKE);
        next_scale_out = (next_free_out | next_brake_out) ? 5'h00 : scale;
    end

    // wishbone register file
    always_comb begin
        next_ctrl = ctrl;
        next_curcfg = curcfg;
        next_ack = bus_req;
        next_dat = 32'h0000_0000;
        if (bus_req && we_i) begin
            case (adr_i)
                sdmi_pkg::ADDR_CTRL: begin
                    next_ctrl = ((ctrl & ~wmask) | (dat_i & wmask)) & sdmi_pkg::CTRL_MASK;
                end
                sdmi_pkg::ADDR_CURCFG: begin
                    next_curcfg = ((curcfg & ~wmask) | (dat_i & wmask)) & sdmi_pkg::CURCFG_MASK;
                end
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end else if (bus_req) begin
            case (adr_i)
                sdmi_pkg::ADDR_CTRL: begin
                    next_dat = ctrl;
                end
                sdmi_pkg::ADDR_CURCFG: begin
                    next_dat = curcfg;
                end
                sdmi_pkg::ADDR_STATUS: begin
                    next_dat[9:0] = mscnt;
                    next_dat[sdmi_pkg::STAT_POS_LSB +: 10] = pos;
                    next_dat[sdmi_pkg::STAT_STILL] = still;
                    next_dat[sdmi_pkg::STAT_EXT] = ext_mode;
                    next_dat[sdmi_pkg::STAT_DIR] = dir_last;
                end
                sdmi_pkg::ADDR_COIL: begin
                    next_dat[8:0] = coil_a_o;
                    next_dat[sdmi_pkg::COIL_B_LSB +: 9] = coil_b_o;
                    next_dat[sdmi_pkg::COIL_SCALE_LSB +: 5] = scale_out;
                end
                default: begin
                    next_dat = 32'h0000_0000;
                end
            endcase
        end
    end

    // pin synchronisers and step edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_sync <= 2'b00;
            dir_sync <= 2'b00;
            ext_sync <= 2'b00;
            step_prev <= 1'b0;
        end else begin
            step_sync <= {step_sync[0], step_i};
            dir_sync <= {dir_sync[0], dir_i};
            ext_sync <= {ext_sync[0], external_pulse_mode_pin_i};
            step_prev <= step_sync[1];
        end
    end

    // microstep counter and standstill power-down state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mscnt <= 10'h000;
            dir_last <= 1'b0;
            still_cnt <= 20'h00000;
            still <= 1'b0;
            tick_cnt <= 15'h0000;
            pd_cnt <= 8'h00;
            decay_cnt <= 4'h0;
            scale <= 5'h1F;
            scale_out <= 5'h1F;
            free_out <= 1'b0;
            brake_out <= 1'b0;
        end else begin
            mscnt <= next_mscnt;
            dir_last <= next_dir_last;
            still_cnt <= next_still_cnt;
            still <= next_still;
            tick_cnt <= next_tick_cnt;
            pd_cnt <= next_pd_cnt;
            decay_cnt <= next_decay_cnt;
            scale <= next_scale;
            scale_out <= next_scale_out;
            free_out <= next_free_out;
            brake_out <= next_brake_out;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= sdmi_pkg::CTRL_RESET;
            curcfg <= sdmi_pkg::CURCFG_RESET;
        end else begin
            ctrl <= next_ctrl;
            curcfg <= next_curcfg;
        end
    end

    // bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    always_comb begin
        cur_scale_o = scale_out;
        freewheel_o = free_out;
        brake_o = brake_out;
        standstill_o = still;
        ramp_gen_en_o = ~ext_mode;
    end

    sdmi_interp u_interp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_evt_i(step_evt),
        .target_i(mscnt),
        .mres_i(mres),
        .interp_en_i(interp_en),
        .pos_o(pos)
    );

    sdmi_sine u_sine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pos_i(pos),
        .sin_o(coil_a_o),
        .cos_o(coil_b_o)
    );
endmodule : sdmi_indexer

// File: testbench/sdmi_indexer_asserts.sv
`timescale 1ns/10ps
module sdmi_indexer_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins
    input wire logic step_i,
    input wire logic external_pulse_mode_pin_i,
    // motor side
    input wire logic [8:0] coil_a_o,
    input wire logic [8:0] coil_b_o,
    input wire logic [4:0] cur_scale_o,
    input wire logic freewheel_o,
    input wire logic brake_o,
    input wire logic standstill_o,
    input wire logic ramp_gen_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a one cycle pulse");
    property p_dat;
        !ack_o |-> dat_o == 32'h0000_0000;
    endproperty
    a_dat: assert property (p_dat) else $error("read data outside answer");
    property p_ramp;
        $stable(external_pulse_mode_pin_i) [*3] ##0 (!$past(rst_i) && !$past(rst_i, 2))
            |-> ramp_gen_en_o != external_pulse_mode_pin_i;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp enable wrong for pin");
    property p_free;
        freewheel_o |-> standstill_o && !brake_o && cur_scale_o == 5'h00;
    endproperty
    a_free: assert property (p_free) else $error("freewheel while not still");
    property p_brake;
        brake_o |-> standstill_o && !freewheel_o && cur_scale_o == 5'h00;
    endproperty
    a_brake: assert property (p_brake) else $error("brake while not still");
    property p_clear;
        $rose(step_i) && external_pulse_mode_pin_i && $past(external_pulse_mode_pin_i, 4)
            |-> ##[1:4] !standstill_o;
    endproperty
    a_clear: assert property (p_clear) else $error("step did not end standstill");
    property p_reduce;
        standstill_o && $past(standstill_o) && !$past(ack_o) && !$past(ack_o, 2)
            |-> cur_scale_o <= $past(cur_scale_o);
    endproperty
    a_reduce: assert property (p_reduce) else $error("scale rose at standstill");
    property p_mag;
        (coil_a_o <= 9'h0F8 || coil_a_o >= 9'h108) && (coil_b_o <= 9'h0F8 || coil_b_o >= 9'h108);
    endproperty
    a_mag: assert property (p_mag) else $error("coil target beyond peak");
    c_free: cover property (freewheel_o);
    c_brake: cover property (brake_o);
    c_still: cover property ($rose(standstill_o));
endmodule : sdmi_indexer_asserts

bind sdmi_indexer sdmi_indexer_asserts u_sdmi_indexer_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .step_i(step_i),
    .external_pulse_mode_pin_i(external_pulse_mode_pin_i), .coil_a_o(coil_a_o),
    .coil_b_o(coil_b_o), .cur_scale_o(cur_scale_o), .freewheel_o(freewheel_o),
    .brake_o(brake_o), .standstill_o(standstill_o), .ramp_gen_en_o(ramp_gen_en_o));

// File: testbench/sdmi_step_src.sv
`timescale 1ns/10ps
module sdmi_step_src (
    // clock
    input wire logic clk_i,
    // step and direction pins
    output logic step_o,
    output logic dir_o
);
    initial begin
        step_o = 1'b0;
        dir_o = 1'b0;
    end
    // n steps, each level held half cycles (at least 2)
    task automatic move(input int n, input logic d, input int half, input logic dedge);
        @(posedge clk_i);
        dir_o <= d;
        // direction settles before the first edge
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            if (dedge) begin
                step_o <= !step_o;
                repeat (half) @(posedge clk_i);
            end else begin
                step_o <= 1'b1;
                repeat (half) @(posedge clk_i);
                step_o <= 1'b0;
                repeat (half) @(posedge clk_i);
            end
        end
    endtask : move
endmodule : sdmi_step_src

// File: testbench/tb_sdmi_indexer.sv
`timescale 1ns/10ps
module tb_sdmi_indexer;
    localparam int STILL = 50;
    localparam int FAST = 20;
    typedef struct packed {
        logic [3:0] mres;
        logic dedge;
        logic dir;
        logic [3:0] n;
        logic [9:0] delta;
    } sdmi_row_t;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, step_i, dir_i, external_pulse_mode_pin_i;
    logic freewheel_o, brake_o, standstill_o, ramp_gen_en_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i, wsel = 4'hF;
    logic [31:0] dat_i, dat_o, rd;
    logic [8:0] coil_a_o, coil_b_o;
    logic [4:0] cur_scale_o;
    logic [9:0] pos;
    int miscompares, n_compared, cnt;
    sdmi_row_t rows [0:10] = '{
        '{4'h0, 1'b0, 1'b0, 4'h3, 10'h003}, '{4'h1, 1'b0, 1'b1, 4'h2, 10'h3FC},
        '{4'h2, 1'b0, 1'b0, 4'h1, 10'h004}, '{4'h3, 1'b0, 1'b1, 4'h1, 10'h3F8},
        '{4'h4, 1'b0, 1'b0, 4'h2, 10'h020}, '{4'h5, 1'b0, 1'b1, 4'h1, 10'h3E0},
        '{4'h6, 1'b0, 1'b0, 4'h3, 10'h0C0}, '{4'h7, 1'b0, 1'b1, 4'h1, 10'h380},
        '{4'h8, 1'b0, 1'b0, 4'h5, 10'h100}, '{4'h8, 1'b1, 1'b1, 4'h2, 10'h200},
        '{4'h0, 1'b1, 1'b0, 4'h4, 10'h004}};
    logic [31:0] cfg [0:3] = '{32'h0000_0008, 32'h0000_0048, 32'h0000_0108, 32'h0000_0208};

    sdmi_indexer #(.STILL_CYC(STILL), .FAST_STILL_CYC(FAST), .PD_TICK_CYC(4)) u_sdmi_indexer (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .step_i(step_i),
        .dir_i(dir_i), .external_pulse_mode_pin_i(external_pulse_mode_pin_i),
        .coil_a_o(coil_a_o), .coil_b_o(coil_b_o), .cur_scale_o(cur_scale_o),
        .freewheel_o(freewheel_o), .brake_o(brake_o), .standstill_o(standstill_o),
        .ramp_gen_en_o(ramp_gen_en_o));
    sdmi_step_src u_sdmi_step_src (.clk_i(clk_i), .step_o(step_i), .dir_o(dir_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic bail();
        miscompares++;
        $display("MISMATCH at %0t: wait timed out", $time);
        give_verdict();
    endtask : bail
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_rng(input int g, input int lo, input int hi);
        n_compared++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("MISMATCH at %0t: %0d not in %0d..%0d", $time, g, lo, hi);
        end
    endtask : chk_rng
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, wsel, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        if (i >= 20) bail();
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask : wb
    function automatic bit cond(input int k);
        case (k)
            0: return standstill_o === 1'b1;
            1: return cur_scale_o === 5'h08;
            2: return freewheel_o === 1'b1;
            default: return brake_o === 1'b1;
        endcase
    endfunction : cond
    task automatic wait_for(input int k);
        cnt = 0;
        while (!cond(k) && cnt < 600) begin
            @(posedge clk_i);
            cnt++;
        end
        if (cnt >= 600) bail();
    endtask : wait_for
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        pos = 10'h000;
    endtask : do_reset
    initial begin
        repeat (100000) @(posedge clk_i);
        bail();
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 8'h00, 4'h0, 32'h0};
        external_pulse_mode_pin_i = 1'b1;
        miscompares = 0;
        n_compared = 0;
        do_reset();
        chk_val(32'({coil_b_o, coil_a_o}), 32'h0001_F000);
        wb(1'b0, sdmi_pkg::ADDR_CTRL, 32'h0);
        chk_val(rd, sdmi_pkg::CTRL_RESET);
        wb(1'b0, sdmi_pkg::ADDR_CURCFG, 32'h0);
        chk_val(rd, sdmi_pkg::CURCFG_RESET);
        wb(1'b1, sdmi_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        chk_val(rd, 32'h0);
        wsel = 4'h2;
        wb(1'b1, sdmi_pkg::ADDR_CURCFG, 32'hFFFF_15FF);
        wsel = 4'hF;
        wb(1'b0, sdmi_pkg::ADDR_CURCFG, 32'h0);
        chk_val(rd, 32'h010A_1508);
        wb(1'b1, sdmi_pkg::ADDR_CURCFG, sdmi_pkg::CURCFG_RESET);
        $display("test reset done");
        for (int r = 0; r < 11; r++) begin
            wb(1'b1, sdmi_pkg::ADDR_CTRL, {26'h0, 1'b0, rows[r].dedge, rows[r].mres});
            u_sdmi_step_src.move(rows[r].n, rows[r].dir, 3, rows[r].dedge);
            repeat (6) @(posedge clk_i);
            pos = pos + rows[r].delta;
            wb(1'b0, sdmi_pkg::ADDR_STATUS, 32'h0);
            chk_val(32'({rd[30], rd[25:16], rd[9:0]}), 32'({rows[r].dir, pos, pos}));
        end
        $display("test step table done");
        @(posedge clk_i);
        external_pulse_mode_pin_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_val(32'(ramp_gen_en_o), 32'h1);
        u_sdmi_step_src.move(2, 1'b0, 3, 1'b0);
        repeat (6) @(posedge clk_i);
        wb(1'b0, sdmi_pkg::ADDR_STATUS, 32'h0);
        chk_val(32'({rd[29], rd[9:0]}), 32'(pos));
        external_pulse_mode_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk_val(32'(ramp_gen_en_o), 32'h0);
        $display("test mode pin done");
        do_reset();
        wb(1'b1, sdmi_pkg::ADDR_CTRL, 32'h0000_0008);
        for (int k = 1; k < 3; k++) begin
            u_sdmi_step_src.move(1, 1'b0, 3, 1'b0);
            repeat (6) @(posedge clk_i);
            chk_val(32'({coil_b_o, coil_a_o}), k == 1 ? 32'h0000_00F8 : 32'h0002_1000);
        end
        wb(1'b1, sdmi_pkg::ADDR_CTRL, 32'h0000_0024);
        u_sdmi_step_src.move(1, 1'b0, 8, 1'b0);
        fork
            u_sdmi_step_src.move(1, 1'b0, 8, 1'b0);
            begin
                repeat (10) @(posedge clk_i);
                wb(1'b0, sdmi_pkg::ADDR_STATUS, 32'h0);
                chk_rng(int'(rd[25:16]), 513, 543);
            end
        join
        repeat (40) @(posedge clk_i);
        wb(1'b0, sdmi_pkg::ADDR_STATUS, 32'h0);
        chk_val(32'(rd[25:16]), 32'h220);
        $display("test interpolation done");
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, sdmi_pkg::ADDR_CTRL, cfg[m]);
            u_sdmi_step_src.move(1, 1'b0, 3, 1'b0);
            wait_for(0);
            chk_rng(cnt, (m == 1 ? FAST : STILL) - 8, (m == 1 ? FAST : STILL) + 2);
            chk_val(32'(cur_scale_o), 32'h1F);
            wait_for(m < 2 ? 1 : m);
            chk_rng(cnt, 200, 250);
            chk_val(32'(cur_scale_o), m < 2 ? 32'h08 : 32'h00);
        end
        $display("test standstill done");
        give_verdict();
    end
endmodule : tb_sdmi_indexer
